// [rtl/ecpmt_pkg.sv]
// Package: register map, field positions, reset values and timing constants of the event/measure timer
package ecpmt_pkg;

	// ==================================================================
	// Register map (word index on the plain register port)
	localparam int          ADDR_W         = 4;
	localparam logic [3:0]  REG_START      = 4'h0;    // Count start flags, bit per channel
	localparam logic [3:0]  REG_MODE0      = 4'h1;    // Mode register channel 0 (2,3 follow)
	localparam logic [3:0]  REG_TIMER0     = 4'h4;    // Timer register channel 0 (5,6 follow)
	localparam logic [3:0]  REG_IRQ        = 4'h7;    // Interrupt request bits, bit per channel

	// ==================================================================
	// Mode register fields
	localparam int          MODE_LSB       = 0;
	localparam int          EDGE_LSB       = 2;
	localparam int          OVF_BIT        = 5;
	localparam int          SRC_LSB        = 6;
	localparam logic [1:0]  MODE_TIMER     = 2'h0;
	localparam logic [1:0]  MODE_EVENT     = 2'h1;
	localparam logic [1:0]  MODE_MEASURE   = 2'h2;
	localparam logic [1:0]  EDGE_FALL      = 2'h0;
	localparam logic [1:0]  EDGE_RISE      = 2'h1;
	localparam logic [1:0]  EDGE_BOTH      = 2'h2;
	localparam logic [7:0]  MODE_RST       = 8'h00;

	// ==================================================================
	// Counter constants
	localparam logic [15:0] CNT_ZERO       = 16'h0000;
	localparam logic [15:0] CNT_ALL1       = 16'hFFFF;
	localparam int          NCH            = 3;

	// ==================================================================
	// Count source dividers (core clock divided by 2, 16, 64, 512)
	localparam int          PRE_W          = 9;
	localparam logic [8:0]  DIV2_MASK      = 9'h001;
	localparam logic [8:0]  DIV16_MASK     = 9'h00F;
	localparam logic [8:0]  DIV64_MASK     = 9'h03F;
	localparam logic [8:0]  DIV512_MASK    = 9'h1FF;

	// Register port command
	typedef struct packed {
		logic              wr;
		logic              rd;
		logic [ADDR_W-1:0] addr;
		logic [15:0]       wdata;
	} ecpmt_req_t;

endpackage : ecpmt_pkg

// [rtl/ecpmt_top.sv]
// Module: three-channel 16-bit event counter and pulse period/width measurement timer
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ns

// Function
// [R1] Mode 01 selects event counting, ignores source
// [R2] Event mode: bit 5 unwritable, reads undefined
// [R3] Event mode: decrement on selected input edge
// [R4] Underflow reloads counter, sets request bit
// [R5] Bits 3:2 pick falling, rising, both edges
// [R6] Write while running updates reload only
// [R7] Event mode read returns counter value
// [R8] Edge detection starts only after start flag
// [R9] Software makes shared port pin an input
// [R10] Mode 10 selects pulse measurement
// [R11] Measure mode: increment on count source tick
// [R12] Active edge copies counter, then clears it
// [R13] Completed measurement sets request with capture
// [R14] First edge after start: no request
// [R15] Measure mode read returns captured value
// [R16] Bits 3:2 select measured interval
// [R17] Wrap to zero sets request and overflow
// [R18] Overflow set at reset, cleared by mode write
// [R19] Source holds levels two count cycles
// [R20] Read at reload moment returns FFFF
// [R21] Both causes share one request
// [R22] Request bit holds until accepted or cleared
// [R23] Write while stopped loads counter and reload
// [R24] Bits 7:6 pick divide by 2,16,64,512
// [R25] Three independent identical channels
// [R26] Input synchronised before edge detection
module ecpmt_top
	import ecpmt_pkg::*;
(
	input  wire logic              ref_clk,
	input  wire logic              rstn,
	input  wire logic [ADDR_W-1:0] reg_addr,
	input  wire logic [15:0]       reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [15:0]       reg_rdata,
	input  wire logic [NCH-1:0]    event_input_pin,
	input  wire logic [NCH-1:0]    irq_ack,
	output logic      [NCH-1:0]    irq_req
);

	// ==================================================================
	// Shared prescaler and count start flags
	logic [PRE_W-1:0] pre_q;
	logic [NCH-1:0]   start_q;
	logic [15:0]      rd_mux;
	logic [15:0]      chan_rd [NCH];
	logic [NCH-1:0]   irq_set;

	// Free-running divider that feeds all channels
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			pre_q <= '0;
		else
			pre_q <= pre_q + 9'h001;
	end

	// Count start flags, one bit per channel
	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			start_q <= '0;
		else if (reg_wr && reg_addr == REG_START)
			start_q <= reg_wdata[NCH-1:0];
	end

	// ==================================================================
	// Per-channel logic
	genvar gi;
	generate
		for (gi = 0; gi < NCH; gi++)
		begin : g_ch // [R25]
			logic [2:0]  sync_q;
			logic        lvl_q;
			logic [7:0]  mode_q;
			logic        ovf_q;
			logic [15:0] cnt_q;
			logic [15:0] rld_q;
			logic        first_q;
			logic        reload_mark_q;
			logic        irq_q;
			logic        edge_rise;
			logic        edge_fall;
			logic        edge_hit;
			logic        tick;
			logic        wr_mode;
			logic        wr_timer;
			logic [1:0]  md;
			logic [1:0]  eg;
			logic        run;

			assign md       = mode_q[MODE_LSB+1:MODE_LSB];
			assign eg       = mode_q[EDGE_LSB+1:EDGE_LSB];
			assign run      = start_q[gi];
			assign wr_mode  = reg_wr && reg_addr == REG_MODE0 + 4'(gi);
			assign wr_timer = reg_wr && reg_addr == REG_TIMER0 + 4'(gi);

			// Three-stage synchroniser; stages two and three confirm a change
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					sync_q <= '0;
				else
					sync_q <= {sync_q[1:0], event_input_pin[gi]}; // [R26]
			end

			// Accepted level follows once stages two and three agree
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					lvl_q <= 1'b0;
				else if (sync_q[1] == sync_q[2])
					lvl_q <= sync_q[2];
			end

			// Edge detection, gated by the start flag
			always_comb
			begin
				edge_rise = run && (sync_q[1] == sync_q[2]) && sync_q[2] && !lvl_q; // [R8] [R26]
				edge_fall = run && (sync_q[1] == sync_q[2]) && !sync_q[2] && lvl_q;
				case (eg) // [R5] [R16]
					EDGE_FALL: edge_hit = edge_fall;
					EDGE_RISE: edge_hit = edge_rise;
					EDGE_BOTH: edge_hit = edge_rise || edge_fall;
					default:   edge_hit = 1'b0;
				endcase
			end

			// Count source tick selection
			always_comb
			begin
				case (mode_q[SRC_LSB+1:SRC_LSB]) // [R24]
					2'h0:    tick = (pre_q & DIV2_MASK) == DIV2_MASK;
					2'h1:    tick = (pre_q & DIV16_MASK) == DIV16_MASK;
					2'h2:    tick = (pre_q & DIV64_MASK) == DIV64_MASK;
					default: tick = (pre_q & DIV512_MASK) == DIV512_MASK;
				endcase
			end

			// Mode register; bit 5 is the overflow flag and never written
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					mode_q <= MODE_RST;
				else if (wr_mode)
				begin
					mode_q <= reg_wdata[7:0];
					mode_q[OVF_BIT] <= 1'b0; // [R2]
				end
			end

			// Overflow flag: set at reset and on wrap, cleared by mode write while running
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					ovf_q <= 1'b1; // [R18]
				else if (md == MODE_MEASURE && run && tick && cnt_q == CNT_ALL1)
					ovf_q <= 1'b1; // [R17]
				else if (wr_mode && run)
					ovf_q <= 1'b0; // [R18]
			end

			// First-edge marker: armed while stopped, dropped at first edge in measure mode
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					first_q <= 1'b1;
				else if (!run)
					first_q <= 1'b1;
				else if (md == MODE_MEASURE && edge_hit)
					first_q <= 1'b0; // [R14]
			end

			// Counter
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					cnt_q <= CNT_ZERO;
				else if (wr_timer && !run && md != MODE_MEASURE)
					cnt_q <= reg_wdata; // [R23]
				else if (run && md == MODE_EVENT && edge_hit) // [R1] [R3]
					cnt_q <= (cnt_q == CNT_ZERO) ? rld_q : cnt_q - 16'h0001; // [R4] [R6]
				else if (run && md == MODE_TIMER && tick)
					cnt_q <= (cnt_q == CNT_ZERO) ? rld_q : cnt_q - 16'h0001;
				else if (run && md == MODE_MEASURE && edge_hit) // [R10]
					cnt_q <= CNT_ZERO; // [R12]
				else if (run && md == MODE_MEASURE && tick)
					cnt_q <= cnt_q + 16'h0001; // [R11]
			end

			// Reload register: loaded by writes, or by capture in measurement
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					rld_q <= CNT_ZERO;
				else if (run && md == MODE_MEASURE && edge_hit)
					rld_q <= cnt_q; // [R12] [R14]
				else if (wr_timer && md != MODE_MEASURE)
					rld_q <= reg_wdata; // [R6] [R23]
			end

			// Marks the cycle right after a reload so a read then returns all ones
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					reload_mark_q <= 1'b0;
				else
					reload_mark_q <= run && md != MODE_MEASURE && cnt_q == CNT_ZERO
						&& (md == MODE_EVENT ? edge_hit : tick); // [R20]
			end

			// Request events of this channel
			assign irq_set[gi] = run && (
				(md != MODE_MEASURE && cnt_q == CNT_ZERO && (md == MODE_EVENT ? edge_hit : tick)) // [R4]
				|| (md == MODE_MEASURE && edge_hit && !first_q) // [R13] [R14]
				|| (md == MODE_MEASURE && tick && !edge_hit && cnt_q == CNT_ALL1)); // [R17] [R21]

			// Interrupt request bit; a new event wins over clear or accept
			always_ff @(posedge ref_clk or negedge rstn)
			begin
				if (!rstn)
					irq_q <= 1'b0;
				else if (irq_set[gi])
					irq_q <= 1'b1; // [R22]
				else if (irq_ack[gi])
					irq_q <= 1'b0;
				else if (reg_wr && reg_addr == REG_IRQ)
					irq_q <= reg_wdata[gi];
			end

			// Readback of this channel for the addressed register
			always_comb
			begin
				if (reg_addr == REG_MODE0 + 4'(gi))
					chan_rd[gi] = {8'h00, mode_q[7:6], ovf_q, mode_q[4:0]}; // [R2]
				else if (reg_addr == REG_TIMER0 + 4'(gi))
				begin
					if (md == MODE_MEASURE)
						chan_rd[gi] = rld_q; // [R15]
					else if (reload_mark_q)
						chan_rd[gi] = CNT_ALL1; // [R20]
					else
						chan_rd[gi] = cnt_q; // [R7]
				end
				else
					chan_rd[gi] = 16'h0000;
			end

			assign irq_req[gi] = irq_q;
		end
	endgenerate

	// ==================================================================
	// Read path: data stands in the cycle after the read strobe
	always_comb
	begin
		rd_mux = 16'h0000;
		if (reg_addr == REG_START)
			rd_mux = {13'h0000, start_q};
		else if (reg_addr == REG_IRQ)
			rd_mux = {13'h0000, irq_req};
		else
			rd_mux = chan_rd[0] | chan_rd[1] | chan_rd[2];
	end

	always_ff @(posedge ref_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 16'h0000;
		else if (reg_rd)
			reg_rdata <= rd_mux;
		else
			reg_rdata <= 16'h0000;
	end

endmodule : ecpmt_top

// [tb/ecpmt_src.sv]
// Partner: external pulse source driving the timer input pins
`timescale 1ns/1ns
module ecpmt_src
	import ecpmt_pkg::*;
#(
	parameter int HOLD = 8
)
(
	input  wire logic           ref_clk,
	input  wire logic           rstn,
	input  wire logic [NCH-1:0] flip,
	output logic      [NCH-1:0] pin_q
);
	logic [7:0] gap_q;
	// Flip requested lines, but only once the last level has been held HOLD clocks
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
		begin
			gap_q <= 8'hFF;
			pin_q <= 3'h0;
		end
		else if (|flip && gap_q >= 8'(HOLD))
		begin
			gap_q <= 8'h00;
			pin_q <= pin_q ^ flip;
		end
		else if (gap_q != 8'hFF)
			gap_q <= gap_q + 8'h01;
endmodule : ecpmt_src

// [tb/ecpmt_top_sva.sv]
// Checker: port-level properties of the event/measure timer
`timescale 1ns/1ns
module ecpmt_top_sva
	import ecpmt_pkg::*;
(
	input wire logic              ref_clk,
	input wire logic              rstn,
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic [15:0]       reg_wdata,
	input wire logic              reg_wr,
	input wire logic              reg_rd,
	input wire logic [15:0]       reg_rdata,
	input wire logic [NCH-1:0]    event_input_pin,
	input wire logic [NCH-1:0]    irq_ack,
	input wire logic [NCH-1:0]    irq_req
);
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	// ==========================================
	// Helper state: channel 0 start and mode, pin age
	logic       start_q;
	logic       ev_q;
	logic       pin_q;
	logic [3:0] age_q;
	logic       irq_wr;
	assign irq_wr = reg_wr && reg_addr == REG_IRQ;
	// Software view of the channel 0 start flag and event mode
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
		begin
			start_q <= 1'b0;
			ev_q    <= 1'b0;
		end
		else if (reg_wr && reg_addr == REG_START)
			start_q <= reg_wdata[0];
		else if (reg_wr && reg_addr == REG_MODE0)
			ev_q <= reg_wdata[1:0] == MODE_EVENT;
	// Cycles since the channel 0 pin last changed, saturating
	always_ff @(posedge ref_clk or negedge rstn)
		if (!rstn)
		begin
			pin_q <= 1'b0;
			age_q <= 4'hF;
		end
		else
		begin
			pin_q <= event_input_pin[0];
			age_q <= (event_input_pin[0] != pin_q) ? 4'h0 : (age_q == 4'hF) ? age_q : age_q + 4'h1;
		end
	// ==========================================
	// Properties
	rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000) else $error("rdata idle");
	unmapped_rd_a: assert property (reg_rd && reg_addr > REG_IRQ |=> reg_rdata == 16'h0000) else $error("unmapped");
	irq_hold_a: assert property (!irq_wr |=> (~irq_req & $past(irq_req) & ~$past(irq_ack)) == 3'h0)
		else $error("irq dropped");
	irq_cause_a: assert property ($rose(irq_req[0]) && ev_q && !$past(irq_wr) |-> age_q inside {[4'h1:4'h8]})
		else $error("irq without edge");
	load_stop_a: assert property (reg_wr && reg_addr == REG_TIMER0 && !start_q && ev_q ##2
		reg_rd && reg_addr == REG_TIMER0 |=> reg_rdata == $past(reg_wdata, 3)) else $error("load");
	ovf_clear_a: assert property (reg_wr && reg_addr == REG_MODE0 && start_q ##2
		reg_rd && reg_addr == REG_MODE0 |=> reg_rdata[OVF_BIT] == 1'b0) else $error("ovf");
	mode_rb_a: assert property (reg_wr && reg_addr == REG_MODE0 ##2 reg_rd && reg_addr == REG_MODE0
		|=> ((reg_rdata ^ $past(reg_wdata, 3)) & 16'h00CF) == 16'h0000) else $error("mode readback");
	start_gate_a: assert property (!start_q && !$past(start_q) && !$past(start_q, 2) && !irq_wr
		|=> !$rose(irq_req[0])) else $error("count while stopped");
	cover property (irq_req[0] && irq_ack[0]);
	cover property (reg_rd && reg_addr == REG_TIMER0);
	cover property ($rose(irq_req[2]));
endmodule : ecpmt_top_sva

// [tb/testbench.sv]
// Testbench: register-port tests of event counting and pulse measurement
`timescale 1ns/1ns
module testbench
	import ecpmt_pkg::*;
;
	logic              ref_clk;
	logic              rstn;
	logic [ADDR_W-1:0] reg_addr;
	logic [15:0]       reg_wdata;
	logic              reg_wr;
	logic              reg_rd;
	logic [15:0]       reg_rdata;
	logic [NCH-1:0]    event_input_pin;
	logic [NCH-1:0]    irq_ack;
	logic [NCH-1:0]    irq_req;
	logic [NCH-1:0]    flip;
	logic [15:0]       rd_v;
	int                errors;
	int                comparisons;
	int                hits;
	ecpmt_top ecpmt_top_inst (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .event_input_pin(event_input_pin),
		.irq_ack(irq_ack), .irq_req(irq_req));
	ecpmt_src #(.HOLD(8)) ecpmt_src_inst (.ref_clk(ref_clk), .rstn(rstn), .flip(flip), .pin_q(event_input_pin));
	// Clock generation
	initial
	begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	// ==========================================
	// Bus and compare tasks
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task automatic rd(input logic [3:0] a);
		@(posedge ref_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		// Data stands only until the next rising edge, so take it mid-cycle
		@(negedge ref_clk);
		rd_v = reg_rdata;
	endtask : rd
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("BAD at %0t got %h expected %h", $time, got, exp);
		end
	endtask : check
	task automatic check_rng(input logic [15:0] got, input logic [15:0] lo, input logic [15:0] hi);
		comparisons++;
		if ((got >= lo && got <= hi) !== 1'b1)
		begin
			errors++;
			$display("BAD at %0t got %h expected %h to %h", $time, got, lo, hi);
		end
	endtask : check_rng
	// One pin change, then a quiet span well above two count periods
	task automatic toggle(input int ch);
		@(posedge ref_clk);
		flip <= 3'h1 << ch;
		@(posedge ref_clk);
		flip <= 3'h0;
		repeat (20) @(posedge ref_clk);
	endtask : toggle
	task automatic report_and_stop();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : report_and_stop
	// Watchdog against a hang
	initial
	begin
		repeat (5000) @(posedge ref_clk);
		errors++;
		report_and_stop();
	end
	// ==========================================
	// Main sequence
	initial
	begin
		rstn      = 1'b0;
		reg_wr    = 1'b0;
		reg_rd    = 1'b0;
		reg_addr  = 4'h0;
		reg_wdata = 16'h0000;
		irq_ack   = 3'h0;
		flip      = 3'h0;
		repeat (3) @(posedge ref_clk);
		rstn <= 1'b1;
		rd(REG_MODE0);
		check(rd_v, 16'h0020);
		rd(4'hF);
		check(rd_v, 16'h0000);
		$display("test reset done");
		// Event counting: channel n uses edge code n, source and bit 5 set to be ignored
		for (int ch = 0; ch < NCH; ch++)
		begin
			hits = 0;
			wr(REG_MODE0 + 4'(ch), {8'h00, 2'h3, 2'h2, ch[1:0], MODE_EVENT});
			rd(REG_MODE0 + 4'(ch));
			check(rd_v, {8'h00, 2'h3, 2'h2, ch[1:0], MODE_EVENT});
			wr(REG_TIMER0 + 4'(ch), 16'h0001);
			rd(REG_TIMER0 + 4'(ch));
			check(rd_v, 16'h0001);
			toggle(ch);
			toggle(ch);
			rd(REG_TIMER0 + 4'(ch));
			check(rd_v, 16'h0001);
			wr(REG_START, 16'h0001 << ch);
			wr(REG_TIMER0 + 4'(ch), 16'h0005);
			rd(REG_TIMER0 + 4'(ch));
			check(rd_v, 16'h0001);
			for (int t = 1; t <= 4; t++)
			begin
				toggle(ch);
				if (ch == 2 || (ch == 1) == (t % 2 == 1))
					hits++;
				check({13'h0000, irq_req}, (hits >= 2) ? 16'h0001 << ch : 16'h0000);
			end
			rd(REG_TIMER0 + 4'(ch));
			check(rd_v, 16'(7 - hits));
			@(posedge ref_clk);
			irq_ack <= 3'h1 << ch;
			@(posedge ref_clk);
			irq_ack <= 3'h0;
			@(posedge ref_clk);
			check({13'h0000, irq_req}, 16'h0000);
			$display("test event channel %0d done", ch);
		end
		// Rising-to-rising period measurement on channel 0 at divide by 2
		wr(REG_START, 16'h0000);
		wr(REG_MODE0, {8'h00, 2'h0, 2'h0, EDGE_RISE, MODE_MEASURE});
		wr(REG_START, 16'h0001);
		toggle(0);
		check({13'h0000, irq_req}, 16'h0000);
		toggle(0);
		toggle(0);
		check({13'h0000, irq_req}, 16'h0001);
		rd(REG_TIMER0);
		check_rng(rd_v, 16'h0015, 16'h0017);
		wr(REG_MODE0, {8'h00, 2'h0, 2'h0, EDGE_RISE, MODE_MEASURE});
		rd(REG_MODE0);
		check(rd_v, 16'h0006);
		wr(REG_IRQ, 16'h0000);
		@(posedge ref_clk);
		check({13'h0000, irq_req}, 16'h0000);
		$display("test measure done");
		report_and_stop();
	end
endmodule : testbench

bind ecpmt_top ecpmt_top_sva ecpmt_top_sva_inst (.ref_clk(ref_clk), .rstn(rstn), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.event_input_pin(event_input_pin), .irq_ack(irq_ack), .irq_req(irq_req));
